/* File: bench/pmu_status_clock_wake_regs_bench.sv */
// self-checking bench for the power unit register slice
// assumes the checker binds itself; reads are scored from a queue
`default_nettype none
module pmu_status_clock_wake_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // stimulus registers, all but p and c given values at time zero
    logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, vbat = 1'b0, busy = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, p, c;
    logic [5:0] cause = 6'h00;
    logic [4:0] wake = 5'h00, rdy = 5'h00;
    logic [1:0] mode = 2'h0;
    // design outputs
    logic awready, wready, bvalid, arready, rvalid, allow, chip_rst, irq;
    logic [1:0] bresp, rresp, sel;
    logic [31:0] rdata;
    // scoreboard state
    logic [33:0] expq [$];
    int num_errors = 0, n_compared = 0, k;
    integer seed;
    // reset value table and ready bit positions
    logic [11:0] rv_a [10] = '{12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C,
        12'h020, 12'h028, 12'h02C, 12'h104};
    int rbit [5] = '{0, 2, 3, 4, 6};
    pmu_status_clock_wake_regs dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .reset_cause_event(cause), .wake_event(wake),
        .wake_mode_code(mode), .vbat_brownout_event(vbat), .main_pll_ready(rdy[0]),
        .rc_fast_osc_ready(rdy[1]), .crystal_slow_ready(rdy[2]), .audio_pll_ready(rdy[3]),
        .crystal_fast_ready(rdy[4]), .rc_cal_busy(busy), .system_clock_sel(sel),
        .rc_cal_allow(allow), .brownout_chip_reset(chip_rst), .irq(irq));
    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end
    // verdict and end of run
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one comparison
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // okay response with data
    function automatic logic [33:0] ok(input logic [31:0] d);
        return {pmu_regs_pkg::RESP_OKAY, d};
    endfunction
    // one write; stall holds bready low for three edges
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er,
        input bit stall);
        int i;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= !stall;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (i == 2) bready <= 1'b1;
        end
        if (i == 40) num_errors++;
        if (i == 40) tally_and_finish();
        chk("bresp", 34'(bresp), 34'(er));
        bready <= 1'b0;
        @(posedge clk);
    endtask
    // one read; expectation queued for the monitor
    task automatic rd(input logic [11:0] a, input logic [33:0] exp, input bit stall);
        int i;
        expq.push_back(exp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= !stall;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (i == 2) rready <= 1'b1;
        end
        if (i == 40) num_errors++;
        if (i == 40) tally_and_finish();
        rready <= 1'b0;
        @(posedge clk);
    endtask
    // brownout pulse; returns at the edge where the chip reset shows
    task automatic vbat_pulse();
        vbat <= 1'b1;
        @(posedge clk);
        vbat <= 1'b0;
        @(posedge clk);
    endtask
    // monitor: scores each read data beat against the oldest note
    always @(posedge clk) begin
        if (rvalid && rready)
            chk("rdata", {rresp, rdata}, expq.size() > 0 ? expq.pop_front() : 34'h0_DEAD_BEEF);
    end
    // main sequence
    initial begin
        seed = 14;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("clk_sel", 34'(sel), 34'h1);
        for (k = 0; k < 10; k++) rd(rv_a[k], ok(k == 4 ? 32'h1 : 32'h0), k[0]);
        // mode code passes through
        for (k = 0; k < 4; k++) begin
            mode <= k[1:0];
            @(posedge clk);
            rd(12'h014, ok(k), 1'b0);
        end
        // every clock select code
        for (k = 0; k < 4; k++) begin
            wr(12'h018, k, pmu_regs_pkg::RESP_OKAY, k[0]);
            chk("clk_sel", 34'(sel), 34'(k));
            rd(12'h018, ok(k), 1'b0);
        end
        // each ready flag alone, then all
        for (k = 0; k < 5; k++) begin
            rdy <= 5'h01 << k;
            @(posedge clk);
            rd(12'h028, ok(32'h1 << rbit[k]), 1'b0);
        end
        rdy <= 5'h1F;
        @(posedge clk);
        rd(12'h028, ok(32'h5D), 1'b1);
        // calibration permission and busy flag
        wr(12'h02C, 32'h2, pmu_regs_pkg::RESP_OKAY, 1'b0);
        chk("cal_allow", 34'(allow), 34'h1);
        busy <= 1'b1;
        @(posedge clk);
        rd(12'h02C, ok(32'h3), 1'b0);
        wr(12'h02C, 32'h1, pmu_regs_pkg::RESP_OKAY, 1'b1);
        chk("cal_allow", 34'(allow), 34'h0);
        busy <= 1'b0;
        @(posedge clk);
        rd(12'h02C, ok(32'h0), 1'b0);
        // brownout raises interrupt when selected and unmasked, none when masked
        wr(12'h104, 32'h2, pmu_regs_pkg::RESP_OKAY, 1'b0);
        vbat_pulse();
        chk("chip_rst", 34'(chip_rst), 34'h0);
        repeat (2) @(posedge clk);
        chk("irq", 34'(irq), 34'h1);
        rd(12'h100, ok(32'h2), 1'b0);
        repeat (2) @(posedge clk);
        chk("irq", 34'(irq), 34'h0);
        wr(12'h104, 32'h0, pmu_regs_pkg::RESP_OKAY, 1'b0);
        vbat_pulse();
        repeat (2) @(posedge clk);
        chk("irq", 34'(irq), 34'h0);
        rd(12'h100, ok(32'h2), 1'b0);
        // brownout resets chip when selected
        wr(12'h020, 32'h1, pmu_regs_pkg::RESP_OKAY, 1'b0);
        rd(12'h020, ok(32'h1), 1'b0);
        vbat_pulse();
        chk("chip_rst", 34'(chip_rst), 34'h1);
        rd(12'h100, ok(32'h0), 1'b0);
        wr(12'h020, 32'h0, pmu_regs_pkg::RESP_OKAY, 1'b0);
        // each reset cause latches, survives a zero write, clears by its bit
        for (k = 0; k < 6; k++) begin
            cause <= 6'h01 << k;
            @(posedge clk);
            cause <= 6'h00;
            rd(12'h008, ok(32'h1 << k), 1'b0);
            wr(12'h00C, 32'h0, pmu_regs_pkg::RESP_OKAY, 1'b0);
            rd(12'h008, ok(32'h1 << k), 1'b0);
            wr(12'h00C, 32'h1 << k, pmu_regs_pkg::RESP_OKAY, 1'b1);
            rd(12'h008, ok(32'h0), 1'b0);
        end
        // random wake patterns latch and clear bit by bit
        for (k = 0; k < 4; k++) begin
            p = $random(seed) & 32'h1F;
            c = $random(seed) & 32'h1F;
            wake <= p[4:0];
            @(posedge clk);
            wake <= 5'h00;
            rd(12'h01C, ok(p), c[0]);
            wr(12'h010, c, pmu_regs_pkg::RESP_OKAY, p[0]);
            rd(12'h01C, ok(p & ~c), 1'b0);
            wr(12'h010, 32'h1F, pmu_regs_pkg::RESP_OKAY, 1'b0);
            rd(12'h01C, ok(32'h0), 1'b0);
        end
        // read-only write ignored, unmapped place refused
        wake <= 5'h11;
        @(posedge clk);
        wake <= 5'h00;
        wr(12'h01C, 32'h0, pmu_regs_pkg::RESP_OKAY, 1'b0);
        rd(12'h01C, ok(32'h11), 1'b0);
        wr(12'h200, 32'h3, pmu_regs_pkg::RESP_SLVERR, 1'b0);
        rd(12'h200, {pmu_regs_pkg::RESP_SLVERR, 32'h0}, 1'b0);
        // reset in mid-run restores the select
        wr(12'h018, 32'h2, pmu_regs_pkg::RESP_OKAY, 1'b0);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("clk_sel", 34'(sel), 34'h1);
        rd(12'h01C, ok(32'h0), 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* File: bench/pmu_status_clock_wake_regs_checker.sv */
// checker for the power unit register slice: bus timing and control outputs
// assumes one clk domain, rst synchronous active high, bound to the top module
`default_nettype none
module pmu_regs_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // control side
    input wire logic vbat_brownout_event,
    input wire logic [1:0] system_clock_sel,
    input wire logic rc_cal_allow,
    input wire logic brownout_chip_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // address and data taken together: response two edges later
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response not on time");
    // no new write accepted while a response waits
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel ready during response");
    // response held steady through a stall
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    // read answered the cycle after the address is taken
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not on time");
    // read data held steady through a stall
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    // select leaves reset on the rc oscillator code
    a_clk_sel_reset: assert property ($fell(rst) |-> system_clock_sel == 2'h1)
        else $error("clock select reset value wrong");
    // permission moves only with a completing write
    a_cal_by_write: assert property ($changed(rc_cal_allow) |-> $past(s_axi_bvalid)
        && !$past(s_axi_bvalid, 2)) else $error("calibration permission changed without write");
    // chip reset pulse only follows a brownout one cycle earlier
    a_brown_pulse: assert property (brownout_chip_reset |-> $past(vbat_brownout_event))
        else $error("chip reset without brownout");
    // main scenarios reached
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
    c_chip_reset: cover property (brownout_chip_reset);
endmodule
bind pmu_status_clock_wake_regs pmu_regs_checker chk_i (.clk(clk), .rst(rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .vbat_brownout_event(vbat_brownout_event), .system_clock_sel(system_clock_sel),
    .rc_cal_allow(rc_cal_allow), .brownout_chip_reset(brownout_chip_reset));
`default_nettype wire

/* File: logic/pmu_regs_pkg.sv */
// constants for the power management status, clock and wake register slice
// assumes a 32-bit register bus with word-aligned byte addresses
// Summary of operation
// - bit 5 clears latched watchdog reset cause
// - bit 4 clears lockup, bit 3 sysreset
// - five wake clear bits, comparator down to pin0
// - two-bit read-only woke-from mode status
// - clock select: 0 loop, 1/3 rc, 2 crystal
// - wake status bits 4,3,2: comparator, rtc, wireless
// - wake status bits 1,0: external pins
// - brownout select: 0 interrupt, 1 chip reset
// - clock ready bit 0 is main pll
// - clock ready bit 2 is rc oscillator
// - bit 3 slow crystal, bit 6 fast crystal
// - clock ready bit 4 is audio pll
// - rc control bit 1 permits calibration commands
// - rc control bit 0 shows calibration running
// - watchdog cause flag reads 1 after watchdog reset
`default_nettype none
package pmu_regs_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_RESET_CAUSE_CLEAR = 12'h00C;
    localparam logic [11:0] OFS_WAKE_SOURCE_CLEAR = 12'h010;
    localparam logic [11:0] OFS_WAKE_MODE_STATUS = 12'h014;
    localparam logic [11:0] OFS_SYSTEM_CLOCK_SELECT = 12'h018;
    localparam logic [11:0] OFS_WAKE_REASON_STATUS = 12'h01C;
    localparam logic [11:0] OFS_BROWNOUT_ACTION_SELECT = 12'h020;
    localparam logic [11:0] OFS_CLOCK_READY_STATUS = 12'h028;
    localparam logic [11:0] OFS_RC_OSC_CALIBRATION_CTRL = 12'h02C;
    // added: reset cause flags, event status, event mask
    localparam logic [11:0] OFS_RESET_CAUSE_STATUS = 12'h008;
    localparam logic [11:0] OFS_EVENT_STATUS = 12'h100;
    localparam logic [11:0] OFS_EVENT_MASK = 12'h104;
    // reset cause bit positions
    localparam int CAUSE_WDT_BIT = 5;
    localparam int CAUSE_LOCKUP_BIT = 4;
    localparam int CAUSE_SYSRESET_BIT = 3;
    localparam int CAUSE_AV18_BIT = 2;
    localparam int CAUSE_V12_BIT = 1;
    localparam int CAUSE_VBAT_BIT = 0;
    localparam int CAUSE_W = 6;
    // wake source bit positions
    localparam int WAKE_COMP_BIT = 4;
    localparam int WAKE_RTC_BIT = 3;
    localparam int WAKE_WL_BIT = 2;
    localparam int WAKE_PIN1_BIT = 1;
    localparam int WAKE_PIN0_BIT = 0;
    localparam int WAKE_W = 5;
    // clock ready bit positions
    localparam int RDY_PLL_BIT = 0;
    localparam int RDY_RC_BIT = 2;
    localparam int RDY_X32K_BIT = 3;
    localparam int RDY_AUPLL_BIT = 4;
    localparam int RDY_X32M_BIT = 6;
    // rc control bit positions
    localparam int CAL_BUSY_BIT = 0;
    localparam int CAL_ALLOW_BIT = 1;
    // event status bit positions
    localparam int EVT_WAKE_BIT = 0;
    localparam int EVT_BROWNOUT_BIT = 1;
    localparam int EVT_CAUSE_BIT = 2;
    localparam int EVT_W = 3;
    // reset values
    localparam logic [1:0] CLK_SEL_RESET = 2'h1;
    localparam logic BROWNOUT_SEL_RESET = 1'b0;
    // clock source codes
    typedef enum logic [1:0] {
        CLK_CODE_LOOP = 2'b00,
        CLK_CODE_RC = 2'b01,
        CLK_CODE_XTAL = 2'b10,
        CLK_CODE_RC_ALT = 2'b11
    } clk_code_t;
    // bus response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: logic/pmu_status_clock_wake_regs.sv */
// register slice of the power unit: cause/wake flags, clock select, ready
// assumes AXI4-Lite master in the clk domain; status inputs synchronous to clk
//
// The AXI4-Lite slave port was decided locally.
`default_nettype none
module pmu_status_clock_wake_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rst,

    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,

    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,

    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,

    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,

    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,

    // reset cause event pulses, one per cause
    input wire logic [5:0] reset_cause_event,

    // wake source event pulses, one per source
    input wire logic [4:0] wake_event,

    // mode woken from, captured by power unit
    input wire logic [1:0] wake_mode_code,

    // battery brownout detection pulse
    input wire logic vbat_brownout_event,

    // clock ready levels
    input wire logic main_pll_ready,
    input wire logic rc_fast_osc_ready,
    input wire logic crystal_slow_ready,
    input wire logic audio_pll_ready,
    input wire logic crystal_fast_ready,

    // calibration busy level from the rc oscillator
    input wire logic rc_cal_busy,

    // control outputs
    output logic [1:0] system_clock_sel,
    output logic rc_cal_allow,
    output logic brownout_chip_reset,
    output logic irq
);
    // write channel holding state
    logic aw_held_r;
    logic w_held_r;
    logic [11:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;

    // registers
    logic [1:0] clk_sel_r;
    logic brownout_sel_r;
    logic cal_allow_r;
    logic [pmu_regs_pkg::EVT_W-1:0] evt_mask_r;
    logic [pmu_regs_pkg::EVT_W-1:0] evt_status_r;
    logic [1:0] wake_mode_r;

    // sampled status
    logic [6:0] ready_r;
    logic cal_busy_r;

    // decoded write pulses
    logic wr_fire;
    logic [pmu_regs_pkg::CAUSE_W-1:0] cause_clr;
    logic [pmu_regs_pkg::WAKE_W-1:0] wake_clr;
    logic [pmu_regs_pkg::CAUSE_W-1:0] cause_flags;
    logic [pmu_regs_pkg::WAKE_W-1:0] wake_flags;
    logic rd_fire;
    logic evt_read;
    logic [pmu_regs_pkg::EVT_W-1:0] evt_set;
    logic [31:0] rd_word;
    logic rd_hit;

    // write happens once address and data both held and no response pending
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

    // take write address, hold until write done
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_fire) begin
            // write done: slot free again
            aw_held_r <= 1'b0;
        end
    end

    // take write data, hold until write done
    always_ff @(posedge clk) begin
        if (rst) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_fire) begin
            // write done: slot free again
            w_held_r <= 1'b0;
        end
    end

    // ready flops: accept while nothing held and no response waits
    // a waiting response blocks too, so only one write is ever under way
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held_r && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // write response, okay for mapped offsets, slverr otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pmu_regs_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            unique case (aw_addr_r)
                pmu_regs_pkg::OFS_RESET_CAUSE_CLEAR, pmu_regs_pkg::OFS_WAKE_SOURCE_CLEAR,
                pmu_regs_pkg::OFS_SYSTEM_CLOCK_SELECT, pmu_regs_pkg::OFS_BROWNOUT_ACTION_SELECT,
                pmu_regs_pkg::OFS_RC_OSC_CALIBRATION_CTRL, pmu_regs_pkg::OFS_EVENT_MASK,
                pmu_regs_pkg::OFS_WAKE_MODE_STATUS, pmu_regs_pkg::OFS_WAKE_REASON_STATUS,
                pmu_regs_pkg::OFS_CLOCK_READY_STATUS, pmu_regs_pkg::OFS_RESET_CAUSE_STATUS,
                pmu_regs_pkg::OFS_EVENT_STATUS: begin
                    s_axi_bresp <= pmu_regs_pkg::RESP_OKAY;
                end
                default: begin
                    s_axi_bresp <= pmu_regs_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_bready) begin
            // response accepted
            s_axi_bvalid <= 1'b0;
        end
    end

    // clear strobes: a write of one clears, zero leaves alone; low lane only
    always_comb begin
        cause_clr = '0;
        wake_clr = '0;
        if (wr_fire && w_strb_r[0]) begin
            if (aw_addr_r == pmu_regs_pkg::OFS_RESET_CAUSE_CLEAR) begin
                cause_clr = w_data_r[pmu_regs_pkg::CAUSE_W-1:0];
            end
            if (aw_addr_r == pmu_regs_pkg::OFS_WAKE_SOURCE_CLEAR) begin
                wake_clr = w_data_r[pmu_regs_pkg::WAKE_W-1:0];
            end
        end
    end

    // latched reset cause flags, bit 5 watchdog
    sticky_flags #(
        .W(pmu_regs_pkg::CAUSE_W)
    ) u_cause (
        .clk(clk),
        .rst(rst),
        .set(reset_cause_event),
        .clr(cause_clr),
        .flags(cause_flags)
    );

    // latched wake source flags
    sticky_flags #(
        .W(pmu_regs_pkg::WAKE_W)
    ) u_wake (
        .clk(clk),
        .rst(rst),
        .set(wake_event),
        .clr(wake_clr),
        .flags(wake_flags)
    );

    // writable control registers; reserved bits are dropped on write
    always_ff @(posedge clk) begin
        if (rst) begin
            clk_sel_r <= pmu_regs_pkg::CLK_SEL_RESET;
            brownout_sel_r <= pmu_regs_pkg::BROWNOUT_SEL_RESET;
            cal_allow_r <= 1'b0;
            evt_mask_r <= '0;
        end else if (wr_fire && w_strb_r[0]) begin
            unique case (aw_addr_r)
                pmu_regs_pkg::OFS_SYSTEM_CLOCK_SELECT: begin
                    clk_sel_r <= w_data_r[1:0];
                end
                pmu_regs_pkg::OFS_BROWNOUT_ACTION_SELECT: begin
                    brownout_sel_r <= w_data_r[0];
                end
                pmu_regs_pkg::OFS_RC_OSC_CALIBRATION_CTRL: begin
                    cal_allow_r <= w_data_r[pmu_regs_pkg::CAL_ALLOW_BIT];
                end
                pmu_regs_pkg::OFS_EVENT_MASK: begin
                    evt_mask_r <= w_data_r[pmu_regs_pkg::EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // sample status levels into the register clock
    always_ff @(posedge clk) begin
        if (rst) begin
            ready_r <= 7'h00;
            cal_busy_r <= 1'b0;
            wake_mode_r <= 2'h0;
        end else begin
            ready_r[pmu_regs_pkg::RDY_PLL_BIT] <= main_pll_ready;
            // reserved ready bits read zero
            ready_r[1] <= 1'b0;
            ready_r[pmu_regs_pkg::RDY_RC_BIT] <= rc_fast_osc_ready;
            ready_r[pmu_regs_pkg::RDY_X32K_BIT] <= crystal_slow_ready;
            ready_r[pmu_regs_pkg::RDY_AUPLL_BIT] <= audio_pll_ready;
            ready_r[5] <= 1'b0;
            ready_r[pmu_regs_pkg::RDY_X32M_BIT] <= crystal_fast_ready;
            cal_busy_r <= rc_cal_busy;
            wake_mode_r <= wake_mode_code;
        end
    end

    // events raising the interrupt: any wake, vbat brownout in interrupt mode, new cause
    always_comb begin
        evt_set = '0;
        evt_set[pmu_regs_pkg::EVT_WAKE_BIT] = |wake_event;
        evt_set[pmu_regs_pkg::EVT_BROWNOUT_BIT] = vbat_brownout_event && !brownout_sel_r;
        evt_set[pmu_regs_pkg::EVT_CAUSE_BIT] = |reset_cause_event;
    end

    // read handshake: one read at a time
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign evt_read = rd_fire && (s_axi_araddr == pmu_regs_pkg::OFS_EVENT_STATUS);

    // event status, cleared by reading it; a set in the same cycle wins
    always_ff @(posedge clk) begin
        if (rst) begin
            evt_status_r <= '0;
        end else begin
            evt_status_r <= evt_set | (evt_read ? '0 : evt_status_r);
        end
    end

    // read decode, reserved bits read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            pmu_regs_pkg::OFS_RESET_CAUSE_STATUS: begin
                rd_word[pmu_regs_pkg::CAUSE_W-1:0] = cause_flags;
            end
            pmu_regs_pkg::OFS_RESET_CAUSE_CLEAR, pmu_regs_pkg::OFS_WAKE_SOURCE_CLEAR: begin
                rd_word = 32'h0000_0000;
            end
            pmu_regs_pkg::OFS_WAKE_MODE_STATUS: begin
                rd_word[1:0] = wake_mode_r;
            end
            pmu_regs_pkg::OFS_SYSTEM_CLOCK_SELECT: begin
                rd_word[1:0] = clk_sel_r;
            end
            pmu_regs_pkg::OFS_WAKE_REASON_STATUS: begin
                rd_word[pmu_regs_pkg::WAKE_W-1:0] = wake_flags;
            end
            pmu_regs_pkg::OFS_BROWNOUT_ACTION_SELECT: begin
                rd_word[0] = brownout_sel_r;
            end
            pmu_regs_pkg::OFS_CLOCK_READY_STATUS: begin
                rd_word[6:0] = ready_r;
            end
            pmu_regs_pkg::OFS_RC_OSC_CALIBRATION_CTRL: begin
                rd_word[pmu_regs_pkg::CAL_ALLOW_BIT] = cal_allow_r;
                rd_word[pmu_regs_pkg::CAL_BUSY_BIT] = cal_busy_r;
            end
            pmu_regs_pkg::OFS_EVENT_STATUS: begin
                rd_word[pmu_regs_pkg::EVT_W-1:0] = evt_status_r;
            end
            pmu_regs_pkg::OFS_EVENT_MASK: begin
                rd_word[pmu_regs_pkg::EVT_W-1:0] = evt_mask_r;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // read channel: arready while idle, data one cycle later
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pmu_regs_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            // address taken: answer next cycle
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? pmu_regs_pkg::RESP_OKAY : pmu_regs_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                // answer accepted: free for the next read
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else begin
            // idle: offer the address channel
            s_axi_arready <= 1'b1;
        end
    end

    // control outputs and interrupt, all registered
    always_ff @(posedge clk) begin
        if (rst) begin
            system_clock_sel <= pmu_regs_pkg::CLK_SEL_RESET;
            rc_cal_allow <= 1'b0;
            brownout_chip_reset <= 1'b0;
            irq <= 1'b0;
        end else begin
            system_clock_sel <= clk_sel_r;
            rc_cal_allow <= cal_allow_r;
            brownout_chip_reset <= vbat_brownout_event && brownout_sel_r;
            irq <= |(evt_status_r & evt_mask_r);
        end
    end
endmodule
`default_nettype wire

/* File: logic/sticky_flags.sv */
// bank of sticky flags: hardware set wins over software clear
// assumes set and clear are single-cycle pulses in the clk domain
`default_nettype none
module sticky_flags #(
    parameter int W = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // set and clear strobes
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    // flag state
    output logic [W-1:0] flags
);
    // one flop per flag
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_flag
            always_ff @(posedge clk) begin
                if (rst) begin
                    flags[i] <= 1'b0;
                end else if (set[i]) begin
                    flags[i] <= 1'b1;
                end else if (clr[i]) begin
                    flags[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire
